// [hw/tbpw_match.sv]
/*
 * pwm output latch: sets at period start unless the next duty is zero, clears at duty match.
 * assumes period_start and time_base come from the timer logic.
 */
`timescale 1ns/100ps

module tbpw_match (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       resetn,
	// control
	input  wire logic       clear,
	input  wire logic       hold,
	input  wire logic       period_start,
	input  wire logic [9:0] next_duty,
	input  wire logic [9:0] active_duty,
	input  wire logic [9:0] time_base,
	// pin level
	output logic            level
);

	typedef struct packed {
		logic level;
	} tbpw_match_state_t;

	tbpw_match_state_t st;
	tbpw_match_state_t next_st;

	always_comb begin
		next_st = st;
		if (clear) begin
			next_st.level = 1'b0; // R21
		end else if (!hold) begin // R16
			if (period_start)
				next_st.level = (next_duty != 10'h000); // R4 R22
			else if (time_base == active_duty)
				next_st.level = 1'b0; // R11 R13 R14
		end
		// drop in the cycle the time base reaches the duty, so high time is duty steps
		level = st.level & (time_base != active_duty); // R11 R13
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			st <= '0;
		else
			st <= next_st;
	end

endmodule

// [hw/tbpw_params.svh]
/*
 * constants for the timer based pwm block: register offsets, field positions,
 * reset values and prescale codes.
 * assumes inclusion by bare name from hw/ and plain 8-bit register data.
 */
`ifndef TBPW_PARAMS_SVH
`define TBPW_PARAMS_SVH

// register offsets
`define TBPW_ADDR_PERIOD_LIMIT   4'h0
`define TBPW_ADDR_TIMER_CONTROL  4'h1
`define TBPW_ADDR_DUTY_HIGH      4'h2
`define TBPW_ADDR_DUTY_ACTIVE    4'h3
`define TBPW_ADDR_PWM_CONTROL    4'h4
`define TBPW_ADDR_TIMER_COUNT    4'h5
`define TBPW_ADDR_STATUS         4'h6

// capture_pwm_control fields
`define TBPW_CTL_MODE_LSB        0
`define TBPW_CTL_MODE_MSB        3
`define TBPW_CTL_DLOW_LSB        4
`define TBPW_CTL_DLOW_MSB        5

// period_timer_control fields
`define TBPW_TCON_PS_LSB         0
`define TBPW_TCON_PS_MSB         1
`define TBPW_TCON_RUN_BIT        2
`define TBPW_TCON_POST_LSB       3
`define TBPW_TCON_POST_MSB       6

// status register fields
`define TBPW_STAT_FLAG_BIT       0
`define TBPW_STAT_PIN_BIT        1

// reset values
`define TBPW_RST_PERIOD_LIMIT    8'hff
`define TBPW_RST_BYTE            8'h00

// prescale codes: 00 is 1:1, 01 is 1:4, 1x is 1:16
`define TBPW_PS_DIV1             2'h0
`define TBPW_PS_DIV4             2'h1

// a one count in the prescaler and its last counts at 1:4 and 1:16
`define TBPW_PS_ONE              4'h1
`define TBPW_PS_LAST4            4'h3
`define TBPW_PS_LAST16           4'hf

`endif

// [hw/tbpw_pkg.sv]
/*
 * types for the timer based pwm block.
 * assumes tbpw_params.svh defines the numeric constants.
 */
package tbpw_pkg;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} tbpw_bus_req_t;

	typedef struct packed {
		logic [7:0] rdata;
	} tbpw_bus_rsp_t;

	typedef struct packed {
		logic       run;
		logic [1:0] prescale;
		logic       sleep;
	} tbpw_tick_ctl_t;

	typedef struct packed {
		logic       step;
		logic [1:0] low_bits;
	} tbpw_tick_t;

	typedef enum logic [1:0] {
		TBPW_OFF,
		TBPW_OTHER,
		TBPW_PWM
	} tbpw_mode_t;

endpackage

// [hw/tbpw_tick.sv]
/*
 * period timer prescaler: a quarter-oscillator counter and a 1/4/16 divider.
 * gives the timer step pulse and the two time-base low bits.
 * assumes clk is the oscillator; frozen while sleep is high.
 */
`timescale 1ns/100ps
`include "tbpw_params.svh"

module tbpw_tick (
	// clock and reset
	input  wire logic                    clk,
	input  wire logic                    resetn,
	// control
	input  wire tbpw_pkg::tbpw_tick_ctl_t ctl,
	// timer step
	output tbpw_pkg::tbpw_tick_t         tick
);

	typedef struct packed {
		logic [1:0] quarter;
		logic [3:0] presc;
	} tbpw_tick_state_t;

	tbpw_tick_state_t st;
	tbpw_tick_state_t next_st;
	logic             last;

	always_comb begin
		next_st = st;
		last = 1'b0;
		if (ctl.prescale == `TBPW_PS_DIV1)
			last = 1'b1;
		else if (ctl.prescale == `TBPW_PS_DIV4)
			last = ({2'h0, st.presc[1:0]} == `TBPW_PS_LAST4);
		else
			last = (st.presc == `TBPW_PS_LAST16);
		if (!ctl.run) begin
			next_st.presc = 4'h0;
		end else if (!ctl.sleep) begin // R16
			next_st.quarter = st.quarter + 2'h1;
			if (st.quarter == 2'h3) begin
				next_st.presc = last ? 4'h0 : st.presc + `TBPW_PS_ONE; // R23
			end
		end
		tick.step = ctl.run & !ctl.sleep & (st.quarter == 2'h3) & last; // R2
		// R10
		if (ctl.prescale == `TBPW_PS_DIV1)
			tick.low_bits = st.quarter;
		else if (ctl.prescale == `TBPW_PS_DIV4)
			tick.low_bits = st.presc[1:0];
		else
			tick.low_bits = st.presc[3:2];
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			st <= '0;
		else
			st <= next_st;
	end

endmodule

// [hw/tbpw_top.sv]
/*
 * timer based pwm output: period timer, double-buffered 10-bit duty, one pin.
 * assumes a plain register port (read data one cycle after the read strobe)
 * and a sleep input held high while the device sleeps.
 */
// Functional notes
// R1 - pwm mode drives a pulse-width waveform on the pin, up to ten bits
// R2 - period is (limit+1) times four oscillator periods times the prescale
// R3 - timer count clears on the increment after it equals the limit
// R4 - pin goes high at each period start unless duty is zero
// R5 - written duty copies into the active buffer at the period boundary
// R6 - duty is eight high bits plus control bits 5:4 as low bits
// R7 - duty writes any time leave the current period undisturbed
// R8 - active duty buffer is read-only while pwm mode is selected
// R9 - active buffer plus hidden 2-bit latch double-buffer the duty
// R10 - time base is timer count plus quarter or prescaler low bits
// R11 - pin goes low when time base matches the buffered duty
// R12 - postscaler setting has no effect on the pwm period
// R13 - high time is duty times oscillator period times prescale
// R14 - duty beyond the period never matches, pin stays unchanged
// R15 - resolution is log2 of 4 times (limit+1), ten bits at 255
// R16 - in sleep the timer and state hold and the pin keeps its level
// R17 - software routes, loads limit, mode, duty, clears flag, starts timer
// R18 - software waits for the timer flag before enabling the driver
// R19 - software clears the pin direction bit to enable the driver
// R20 - mode values with both upper bits set select pwm mode
// R21 - mode zero turns the unit off and resets its state and latch
// R22 - zero duty keeps the pin low for the whole period
// R23 - prescaler divides by 1, 4 or 16
`timescale 1ns/100ps
`include "tbpw_params.svh"

module tbpw_top (
	// clock and reset
	input  wire logic                    clk,
	input  wire logic                    resetn,
	// register port
	input  wire tbpw_pkg::tbpw_bus_req_t bus_req,
	output tbpw_pkg::tbpw_bus_rsp_t      bus_rsp,
	// power state
	input  wire logic                    sleep,
	// pin routing
	input  wire logic                    output_pin_route,
	input  wire logic                    pin_direction_bit,
	// pin
	output logic                         pwm_out_pin,
	output logic                         pwm_out_pin_oe
);

	typedef struct packed {
		logic [7:0]              period_limit_reg;
		logic [7:0]              period_timer_control;
		logic [7:0]              duty_high_bits_reg;
		logic [7:0]              duty_active_buffer;
		logic [1:0]              duty_low_latch;
		logic [3:0]              unit_mode_select;
		logic [1:0]              duty_low_bits;
		logic [7:0]              period_timer_count;
		logic                    period_timer_flag;
		logic                    pin;
		logic                    pin_oe;
		tbpw_pkg::tbpw_bus_rsp_t rsp;
	} tbpw_state_t;

	tbpw_state_t             st;
	tbpw_state_t             next_st;
	tbpw_pkg::tbpw_mode_t    mode;
	tbpw_pkg::tbpw_tick_ctl_t tick_ctl;
	tbpw_pkg::tbpw_tick_t    tick;
	logic                    wrap;
	logic                    period_start;
	logic [9:0]              next_duty;
	logic [9:0]              active_duty;
	logic [9:0]              time_base;
	logic                    level;
	logic                    wr_ctl;

	always_comb begin
		if (st.unit_mode_select == 4'h0)
			mode = tbpw_pkg::TBPW_OFF;
		else if (st.unit_mode_select[3:2] == 2'h3)
			mode = tbpw_pkg::TBPW_PWM; // R20
		else
			mode = tbpw_pkg::TBPW_OTHER;
	end

	// postscaler bits are stored but never reach the prescaler
	assign tick_ctl.run = st.period_timer_control[`TBPW_TCON_RUN_BIT]; // R12
	assign tick_ctl.prescale = st.period_timer_control[`TBPW_TCON_PS_MSB:`TBPW_TCON_PS_LSB];
	assign tick_ctl.sleep = sleep;

	tbpw_tick u_tick (
		.clk    (clk),
		.resetn (resetn),
		.ctl    (tick_ctl),
		.tick   (tick)
	);

	assign wrap = (st.period_timer_count == st.period_limit_reg); // R3
	assign period_start = tick.step & wrap & (mode == tbpw_pkg::TBPW_PWM);
	assign next_duty = {st.duty_high_bits_reg, st.duty_low_bits}; // R6
	assign active_duty = {st.duty_active_buffer, st.duty_low_latch}; // R9
	assign time_base = {st.period_timer_count, tick.low_bits}; // R10 R15

	tbpw_match u_match (
		.clk          (clk),
		.resetn       (resetn),
		.clear        (mode != tbpw_pkg::TBPW_PWM),
		.hold         (sleep),
		.period_start (period_start),
		.next_duty    (next_duty),
		.active_duty  (active_duty),
		.time_base    (time_base),
		.level        (level)
	);

	assign wr_ctl = bus_req.wr & (bus_req.addr == `TBPW_ADDR_PWM_CONTROL);

	always_comb begin
		next_st = st;
		// period timer
		if (tick.step) begin
			if (wrap) begin
				next_st.period_timer_count = 8'h00; // R3
				next_st.period_timer_flag = 1'b1;
			end else begin
				next_st.period_timer_count = st.period_timer_count + 8'h01; // R2
			end
		end
		if (period_start) begin
			next_st.duty_active_buffer = st.duty_high_bits_reg; // R5
			next_st.duty_low_latch = st.duty_low_bits; // R5 R9
		end
		// register writes touch the software copy of the duty, and the active buffer only outside pwm mode
		if (bus_req.wr) begin
			unique case (bus_req.addr)
				`TBPW_ADDR_PERIOD_LIMIT: begin
					next_st.period_limit_reg = bus_req.wdata;
				end
				`TBPW_ADDR_TIMER_CONTROL: begin
					next_st.period_timer_control = {1'b0, bus_req.wdata[6:0]};
				end
				`TBPW_ADDR_DUTY_HIGH: begin
					next_st.duty_high_bits_reg = bus_req.wdata; // R7
				end
				`TBPW_ADDR_DUTY_ACTIVE: begin
					if (mode != tbpw_pkg::TBPW_PWM)
						next_st.duty_active_buffer = bus_req.wdata; // R8
				end
				`TBPW_ADDR_PWM_CONTROL: begin
					next_st.unit_mode_select =
						bus_req.wdata[`TBPW_CTL_MODE_MSB:`TBPW_CTL_MODE_LSB];
					next_st.duty_low_bits =
						bus_req.wdata[`TBPW_CTL_DLOW_MSB:`TBPW_CTL_DLOW_LSB]; // R6 R7
				end
				`TBPW_ADDR_TIMER_COUNT: begin
					next_st.period_timer_count = bus_req.wdata;
				end
				`TBPW_ADDR_STATUS: begin
					// write one clears; a wrap in the same cycle wins
					if (bus_req.wdata[`TBPW_STAT_FLAG_BIT] && !(tick.step && wrap))
						next_st.period_timer_flag = 1'b0;
				end
				default: begin
				end
			endcase
		end
		// a mode zero write clears the hidden duty low latch
		if (wr_ctl && bus_req.wdata[`TBPW_CTL_MODE_MSB:`TBPW_CTL_MODE_LSB] == 4'h0) begin
			next_st.duty_low_latch = 2'h0; // R21
		end
		// read data, valid in the cycle after the strobe
		next_st.rsp.rdata = 8'h00;
		if (bus_req.rd) begin
			unique case (bus_req.addr)
				`TBPW_ADDR_PERIOD_LIMIT:  next_st.rsp.rdata = st.period_limit_reg;
				`TBPW_ADDR_TIMER_CONTROL: next_st.rsp.rdata = st.period_timer_control;
				`TBPW_ADDR_DUTY_HIGH:     next_st.rsp.rdata = st.duty_high_bits_reg;
				`TBPW_ADDR_DUTY_ACTIVE:   next_st.rsp.rdata = st.duty_active_buffer; // R8
				`TBPW_ADDR_PWM_CONTROL: begin
					next_st.rsp.rdata = {2'h0, st.duty_low_bits, st.unit_mode_select};
				end
				`TBPW_ADDR_TIMER_COUNT:   next_st.rsp.rdata = st.period_timer_count;
				`TBPW_ADDR_STATUS: begin
					next_st.rsp.rdata = {6'h00, st.pin, st.period_timer_flag};
				end
				default:                  next_st.rsp.rdata = 8'h00;
			endcase
		end
		// pin: latch level only when routed and in pwm mode
		next_st.pin = output_pin_route & (mode == tbpw_pkg::TBPW_PWM) & level; // R1
		next_st.pin_oe = output_pin_route & !pin_direction_bit; // R19
		if (sleep) begin
			next_st.pin = st.pin; // R16
			next_st.pin_oe = st.pin_oe;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st <= '0;
			st.period_limit_reg <= `TBPW_RST_PERIOD_LIMIT;
		end else begin
			st <= next_st;
		end
	end

	assign bus_rsp = st.rsp;
	assign pwm_out_pin = st.pin;
	assign pwm_out_pin_oe = st.pin_oe;

endmodule

// [tb/tbpw_load.sv]
/*
 * load on the pwm pin: counts pulse high time and rise-to-rise period in clocks.
 * assumes a pull-down holds the pin low while nothing drives it.
 */
`timescale 1ns/100ps

module tbpw_load (
	// clock
	input  wire logic        clk,
	// pin
	input  wire logic        pin,
	input  wire logic        oe,
	// measurements
	output logic      [15:0] rises,
	output logic      [15:0] hi_len,
	output logic      [15:0] per_len
);
	logic        lvl;
	logic        prev;
	logic [15:0] hi_cnt;
	logic [15:0] per_cnt;

	// released pin reads low
	assign lvl = oe & pin;

	initial begin
		prev = 1'b0;
		rises = 16'h0000;
		hi_len = 16'h0000;
		per_len = 16'h0000;
		hi_cnt = 16'h0000;
		per_cnt = 16'h0000;
	end

	always @(posedge clk) begin
		prev <= lvl;
		if (lvl && !prev) begin
			rises <= rises + 16'h0001;
			per_len <= per_cnt;
			per_cnt <= 16'h0001;
			hi_cnt <= 16'h0001;
		end else begin
			per_cnt <= per_cnt + 16'h0001;
			hi_cnt <= hi_cnt + {15'h0000, lvl};
		end
		if (!lvl && prev)
			hi_len <= hi_cnt;
	end
endmodule

// [tb/tbpw_top_asserts.sv]
/*
 * checker on tbpw_top ports: pin enable, sleep hold, mode off, readback.
 * assumes binding to every tbpw_top instance.
 */
`timescale 1ns/100ps
`include "tbpw_params.svh"

module tbpw_top_asserts (
	// clock and reset
	input  wire logic                    clk,
	input  wire logic                    resetn,
	// register port
	input  wire tbpw_pkg::tbpw_bus_req_t bus_req,
	input  wire tbpw_pkg::tbpw_bus_rsp_t bus_rsp,
	// power and routing
	input  wire logic                    sleep,
	input  wire logic                    output_pin_route,
	input  wire logic                    pin_direction_bit,
	// pin
	input  wire logic                    pwm_out_pin,
	input  wire logic                    pwm_out_pin_oe
);
	logic [7:0] lim;

	// tracks the written period limit
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			lim <= `TBPW_RST_PERIOD_LIMIT;
		else if (bus_req.wr && bus_req.addr == `TBPW_ADDR_PERIOD_LIMIT)
			lim <= bus_req.wdata;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence rd_of(logic [3:0] a);
		bus_req.rd && bus_req.addr == a;
	endsequence

	sequence off_wr;
		bus_req.wr && bus_req.addr == `TBPW_ADDR_PWM_CONTROL && bus_req.wdata[3:0] == 4'h0;
	endsequence

	oe_on_a: assert property (!sleep && output_pin_route && !pin_direction_bit |=>
		pwm_out_pin_oe)
		else $error("driver off while routed and enabled");
	oe_dir_a: assert property (!sleep && pin_direction_bit |=> !pwm_out_pin_oe)
		else $error("driver on while direction is input");
	oe_route_a: assert property (!sleep && !output_pin_route |=> !pwm_out_pin_oe)
		else $error("driver on while not routed");
	unrouted_low_a: assert property (!output_pin_route && !$past(output_pin_route) |-> !pwm_out_pin)
		else $error("pin high while not routed");
	sleep_hold_a: assert property (sleep && $past(sleep) |-> $stable(pwm_out_pin))
		else $error("pin moved during sleep");
	mode_off_a: assert property (off_wr |-> ##4 !pwm_out_pin)
		else $error("pin high after unit off");
	ctl_top_a: assert property (rd_of(`TBPW_ADDR_PWM_CONTROL) |=> bus_rsp.rdata[7:6] == 2'h0)
		else $error("control bits 7:6 not zero");
	count_limit_a: assert property (rd_of(`TBPW_ADDR_TIMER_COUNT) |=> bus_rsp.rdata <= lim)
		else $error("timer count above limit");
endmodule

bind tbpw_top tbpw_top_asserts chk_u (
	.clk(clk), .resetn(resetn), .bus_req(bus_req), .bus_rsp(bus_rsp), .sleep(sleep),
	.output_pin_route(output_pin_route), .pin_direction_bit(pin_direction_bit),
	.pwm_out_pin(pwm_out_pin), .pwm_out_pin_oe(pwm_out_pin_oe)
);

// [tb/tbpw_top_tb_top.sv]
/*
 * bench for tbpw_top: register tasks, pulse measurement through the load model.
 * assumes the checker is bound to the design and tbpw_load sits on the pin.
 */
`timescale 1ns/100ps

module tbpw_top_tb_top;
	logic                    clk;
	logic                    resetn;
	logic                    sleep;
	logic                    route;
	logic                    dir;
	logic                    pin;
	logic                    oe;
	tbpw_pkg::tbpw_bus_req_t req;
	tbpw_pkg::tbpw_bus_rsp_t rsp;
	logic [15:0]             rises;
	logic [15:0]             hi_len;
	logic [15:0]             per_len;
	logic [7:0]              d;
	logic [7:0]              c1;
	int                      mismatches = 0;
	int                      checked = 0;
	int                      cyc = 0;

	tbpw_top dut_u (.clk(clk), .resetn(resetn), .bus_req(req), .bus_rsp(rsp), .sleep(sleep),
		.output_pin_route(route), .pin_direction_bit(dir), .pwm_out_pin(pin),
		.pwm_out_pin_oe(oe));
	tbpw_load load_u (.clk(clk), .pin(pin), .oe(oe), .rises(rises), .hi_len(hi_len),
		.per_len(per_len));

	task close_out;
		if (mismatches == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk);
		req.addr <= a;
		req.wdata <= v;
		req.wr <= 1'b1;
		@(posedge clk);
		req.wr <= 1'b0;
	endtask

	task rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge clk);
		req.addr <= a;
		req.rd <= 1'b1;
		@(posedge clk);
		req.rd <= 1'b0;
		@(negedge clk);
		v = rsp.rdata;
	endtask

	task rchk(input logic [3:0] a, input logic [7:0] e);
		rd(a, d);
		chk({8'h00, d}, {8'h00, e});
	endtask

	task meas(input int n, input logic [15:0] h, input logic [15:0] p);
		int r;
		r = rises;
		while (rises != 16'(r + n))
			@(posedge clk);
		@(negedge clk);
		chk(hi_len, h);
		chk(per_len, p);
	endtask

	task flat(input logic e);
		int k;
		k = 0;
		repeat (40) @(posedge clk);
		repeat (32) begin
			@(negedge clk);
			if (pin === e)
				k++;
		end
		chk(16'(k), 16'd32);
	endtask

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			mismatches++;
			close_out;
		end
	end

	initial begin
		resetn = 1'b0;
		sleep = 1'b0;
		route = 1'b0;
		dir = 1'b1;
		req = '0;
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		for (int i = 0; i < 8; i++)
			rchk(4'(i), (i == 0) ? 8'hff : 8'h00);
		@(posedge clk);
		route <= 1'b1;
		wr(4'h0, 8'h03);
		wr(4'h4, 8'hec);
		wr(4'h2, 8'h01);
		wr(4'h6, 8'h01);
		wr(4'h1, 8'hfe);
		rchk(4'h4, 8'h2c);
		rchk(4'h1, 8'h7e);
		d = 8'h00;
		while (d[0] !== 1'b1)
			rd(4'h6, d);
		@(posedge clk);
		dir <= 1'b0;
		for (int i = 0; i < 3; i++) begin
			wr(4'h1, 8'hfe - 8'(i));
			wr(4'h4, 8'h2c + 8'(i));
			meas(3, 16'(6 * (16 >> (2 * i))), 16'(16 * (16 >> (2 * i))));
		end
		wr(4'h2, 8'h02);
		meas(1, 16'd6, 16'd16);
		meas(2, 16'd10, 16'd16);
		wr(4'h3, 8'haa);
		rchk(4'h3, 8'h02);
		@(posedge clk);
		sleep <= 1'b1;
		rd(4'h5, c1);
		repeat (10) @(posedge clk);
		rchk(4'h5, c1);
		@(posedge clk);
		sleep <= 1'b0;
		meas(2, 16'd10, 16'd16);
		wr(4'h2, 8'h00);
		wr(4'h4, 8'h0e);
		flat(1'b0);
		wr(4'h2, 8'hff);
		wr(4'h4, 8'h3f);
		flat(1'b1);
		wr(4'h4, 8'h00);
		flat(1'b0);
		close_out;
	end
endmodule
